// *** sia_alu.sv ***
`timescale 1ns/10ps
module sia_alu
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // request from decode
  input  wire sia_pkg::sia_req_t req,
  // registered result
  output sia_pkg::sia_rsp_t      rsp
);

  // all checks below run on the core clock and rest while reset is low
  default clocking sia_cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // a - b - bin over 9 bits: bit 8 is the borrow out
  function automatic logic [8:0] sub9(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       bin);
    sub9 = {1'b0, a} - {1'b0, b} - {8'h00, bin};
  endfunction : sub9

  function automatic logic [4:0] sub5(input logic [3:0] a,
                                      input logic [3:0] b,
                                      input logic       bin);
    sub5 = {1'b0, a} - {1'b0, b} - {4'h0, bin};
  endfunction : sub5

  logic [7:0]          op_a;
  logic [7:0]          op_b;
  logic                op_c;
  logic [8:0]          diff;
  logic [4:0]          hdiff;
  sia_pkg::sia_rsp_t   next_rsp;

  always_comb
  begin
    op_a = req.mem_data;
    op_b = req.work_register;
    op_c = 1'b0;
    next_rsp = sia_pkg::RSP_RESET;
    next_rsp.valid = req.valid;
    next_rsp.to_mem = 1'b1;
    next_rsp.flags_we = req.valid;
    unique case (req.op)
      sia_pkg::SIA_OP_SUB_MA:
      begin
        op_a = req.mem_data;
        op_b = req.work_register;
      end
      sia_pkg::SIA_OP_SUBC_AM:
      begin
        op_a = req.work_register;
        op_b = req.mem_data;
        op_c = req.carry_in;
        next_rsp.to_mem = 1'b0;
        next_rsp.to_work = 1'b1;
      end
      sia_pkg::SIA_OP_SUBC_MA:
      begin
        op_a = req.mem_data;
        op_b = req.work_register;
        op_c = req.carry_in;
      end
      sia_pkg::SIA_OP_SUBC_A:
      begin
        op_a = req.work_register;
        op_b = sia_pkg::ZERO_BYTE;
        op_c = req.carry_in;
        next_rsp.to_mem = 1'b0;
        next_rsp.to_work = 1'b1;
      end
      sia_pkg::SIA_OP_SUBC_M:
      begin
        op_a = req.mem_data;
        op_b = sia_pkg::ZERO_BYTE;
        op_c = req.carry_in;
      end
      sia_pkg::SIA_OP_INC_M:
      begin
        // sum and flags come from the add path below
        op_a = req.mem_data;
        op_b = sia_pkg::ZERO_BYTE;
      end
      sia_pkg::SIA_OP_DEC_M:
      begin
        op_a = req.mem_data;
        op_b = sia_pkg::ONE_BYTE;
      end
      sia_pkg::SIA_OP_CLEAR_M:
      begin
        op_a = sia_pkg::ZERO_BYTE;
        op_b = sia_pkg::ZERO_BYTE;
        next_rsp.flags_we = 1'b0;
      end
    endcase
    diff  = sub9(op_a, op_b, op_c);
    hdiff = sub5(op_a[3:0], op_b[3:0], op_c);
    next_rsp.data = diff[7:0];
    // carry = borrow out of bit 7, half carry = borrow out of bit 3
    next_rsp.flags.carry = diff[sia_pkg::DATA_W];
    next_rsp.flags.half_carry_flag = hdiff[sia_pkg::HALF_BIT];
    next_rsp.flags.signed_wrap_flag =
      (op_a[sia_pkg::SIGN_BIT] ^ op_b[sia_pkg::SIGN_BIT]) &
      (op_a[sia_pkg::SIGN_BIT] ^ diff[sia_pkg::SIGN_BIT]);
    if (req.op == sia_pkg::SIA_OP_INC_M)
    begin
      // add one: carry out of bit 7 and bit 3
      diff = {1'b0, req.mem_data} + {1'b0, sia_pkg::ONE_BYTE};
      next_rsp.data = diff[7:0];
      next_rsp.flags.carry = diff[sia_pkg::DATA_W];
      next_rsp.flags.half_carry_flag = (req.mem_data[3:0] == 4'hF);
      next_rsp.flags.signed_wrap_flag = ~req.mem_data[sia_pkg::SIGN_BIT] &
                                        diff[sia_pkg::SIGN_BIT];
    end
    next_rsp.flags.zero = (next_rsp.data == sia_pkg::ZERO_BYTE);
    if (!req.valid)
    begin
      next_rsp = sia_pkg::RSP_RESET;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rsp <= sia_pkg::RSP_RESET;
    else
      rsp <= next_rsp;
  end

  a_sub_ma_data: assert property (
    req.valid && req.op == sia_pkg::SIA_OP_SUB_MA |=>
    rsp.to_mem && !rsp.to_work && rsp.data == 8'($past(req.mem_data)
      - $past(req.work_register)))
    else $error("sub M,a result wrong");

  a_sub_ma_borrow: assert property (
    req.valid && req.op == sia_pkg::SIA_OP_SUB_MA |=>
    rsp.flags.carry == ($past(req.mem_data) < $past(req.work_register)))
    else $error("sub M,a borrow wrong");

  a_subc_am_data: assert property (
    req.valid && req.op == sia_pkg::SIA_OP_SUBC_AM |=>
    rsp.to_work && !rsp.to_mem && rsp.data == 8'($past(req.work_register)
      - $past(req.mem_data) - {7'h00, $past(req.carry_in)}))
    else $error("subc a,M result wrong");

  a_subc_ma_data: assert property (
    req.valid && req.op == sia_pkg::SIA_OP_SUBC_MA |=>
    rsp.to_mem && !rsp.to_work && rsp.data == 8'($past(req.mem_data)
      - $past(req.work_register) - {7'h00, $past(req.carry_in)}))
    else $error("subc M,a result wrong");

  a_subc_a_data: assert property (
    req.valid && req.op == sia_pkg::SIA_OP_SUBC_A |=>
    rsp.to_work && !rsp.to_mem && rsp.data == 8'($past(req.work_register)
      - {7'h00, $past(req.carry_in)}))
    else $error("subc a result wrong");

  a_subc_m_data: assert property (
    req.valid && req.op == sia_pkg::SIA_OP_SUBC_M |=>
    rsp.to_mem && !rsp.to_work && rsp.data == 8'($past(req.mem_data)
      - {7'h00, $past(req.carry_in)}))
    else $error("subc M result wrong");

  a_subc_m_half: assert property (
    req.valid && req.op == sia_pkg::SIA_OP_SUBC_M |=>
    rsp.flags.half_carry_flag ==
      ($past(req.mem_data[3:0]) == 4'h0 && $past(req.carry_in)))
    else $error("subc M half borrow wrong");

  a_inc_m_data: assert property (
    req.valid && req.op == sia_pkg::SIA_OP_INC_M |=>
    rsp.to_mem && !rsp.to_work &&
    rsp.data == 8'($past(req.mem_data) + 8'h01))
    else $error("inc M result wrong");

  a_inc_m_carry: assert property (
    req.valid && req.op == sia_pkg::SIA_OP_INC_M |=>
    rsp.flags_we && rsp.flags.carry == ($past(req.mem_data) == 8'hFF))
    else $error("inc M carry wrong");

  a_dec_m_data: assert property (
    req.valid && req.op == sia_pkg::SIA_OP_DEC_M |=>
    rsp.to_mem && rsp.data == 8'($past(req.mem_data) - 8'h01) &&
    rsp.flags.carry == ($past(req.mem_data) == 8'h00))
    else $error("dec M result or borrow wrong");

  a_clear_m_zero: assert property (
    req.valid && req.op == sia_pkg::SIA_OP_CLEAR_M |=>
    rsp.to_mem && rsp.data == 8'h00 && !rsp.flags_we)
    else $error("clear M wrong");

  a_flags_we_arith: assert property (
    req.valid && req.op != sia_pkg::SIA_OP_CLEAR_M |=>
    rsp.flags_we && rsp.valid)
    else $error("flags not written");

  a_zero_flag_ok: assert property (
    rsp.flags_we |-> rsp.flags.zero == (rsp.data == 8'h00))
    else $error("zero flag wrong");

  a_idle_quiet: assert property (
    !req.valid |=> !rsp.valid && !rsp.to_mem && !rsp.to_work)
    else $error("output without request");

  c_subc_borrow: cover property (@(posedge core_clk) disable iff (!rstn)
    rsp.valid && rsp.flags.carry && !rsp.to_mem);
  c_inc_wrap: cover property (@(posedge core_clk) disable iff (!rstn)
    req.valid && req.op == sia_pkg::SIA_OP_INC_M && req.mem_data == 8'hFF);
  c_signed_wrap: cover property (@(posedge core_clk) disable iff (!rstn)
    rsp.valid && rsp.flags.signed_wrap_flag);
  c_clear: cover property (@(posedge core_clk) disable iff (!rstn)
    req.valid && req.op == sia_pkg::SIA_OP_CLEAR_M ##1 req.valid);
endmodule : sia_alu

// *** sia_pkg.sv ***
package sia_pkg;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned SIGN_BIT = 7;
  localparam int unsigned HALF_BIT = 4;

  // operation select, binary codes
  typedef enum logic [2:0]
  {
    SIA_OP_SUB_MA   = 3'h0,
    SIA_OP_SUBC_AM  = 3'h1,
    SIA_OP_SUBC_MA  = 3'h2,
    SIA_OP_SUBC_A   = 3'h3,
    SIA_OP_SUBC_M   = 3'h4,
    SIA_OP_INC_M    = 3'h5,
    SIA_OP_DEC_M    = 3'h6,
    SIA_OP_CLEAR_M  = 3'h7
  } sia_op_t;

  typedef struct packed
  {
    logic zero;
    logic carry;
    logic half_carry_flag;
    logic signed_wrap_flag;
  } sia_flags_t;

  typedef struct packed
  {
    logic              valid;
    sia_op_t           op;
    logic [7:0]        work_register;
    logic [7:0]        mem_data;
    logic              carry_in;
  } sia_req_t;

  typedef struct packed
  {
    logic              valid;
    logic              to_mem;
    logic              to_work;
    logic              flags_we;
    logic [7:0]        data;
    sia_flags_t        flags;
  } sia_rsp_t;

  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE  = 8'h01;
  localparam sia_rsp_t   RSP_RESET = '0;
endpackage : sia_pkg

// *** test_subtract_increment_alu.sv ***
`timescale 1ns/10ps
module test_subtract_increment_alu;
  logic              core_clk;
  logic              rstn;
  sia_pkg::sia_req_t req;
  sia_pkg::sia_rsp_t rsp;
  sia_pkg::sia_rsp_t exp_q[$];
  sia_pkg::sia_rsp_t e;
  sia_pkg::sia_op_t  op_q[$];
  sia_pkg::sia_op_t  eop;
  int                error_cnt;
  int                comparisons;
  logic [19:0]       rv;
  logic [7:0]        vals[6] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'h10, 8'hFF};

  sia_alu sia_alu_inst (.core_clk(core_clk), .rstn(rstn), .req(req),
                        .rsp(rsp));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // expected response worked out from operands
  function automatic sia_pkg::sia_rsp_t model(input sia_pkg::sia_req_t q);
    sia_pkg::sia_rsp_t r;
    logic [7:0]        a;
    logic [7:0]        b;
    logic              c;
    logic [8:0]        d;
    logic [4:0]        h;
    r = '0;
    a = q.mem_data;
    b = q.work_register;
    c = q.carry_in;
    case (q.op)
      sia_pkg::SIA_OP_SUB_MA: c = 1'b0;
      sia_pkg::SIA_OP_SUBC_MA: c = q.carry_in;
      sia_pkg::SIA_OP_SUBC_AM:
      begin
        a = q.work_register;
        b = q.mem_data;
      end
      sia_pkg::SIA_OP_SUBC_A:
      begin
        a = q.work_register;
        b = 8'h00;
      end
      sia_pkg::SIA_OP_SUBC_M: b = 8'h00;
      default:
      begin
        b = 8'h01;
        c = 1'b0;
      end
    endcase
    d = {1'b0, a} - {1'b0, b} - {8'h00, c};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
    r.flags.signed_wrap_flag = (a[7] != b[7]) && (d[7] != a[7]);
    if (q.op == sia_pkg::SIA_OP_INC_M)
    begin
      d = {1'b0, a} + 9'h001;
      h = {1'b0, a[3:0]} + 5'h01;
      r.flags.signed_wrap_flag = d[7] & ~a[7];
    end
    r.valid                 = 1'b1;
    r.data                  = d[7:0];
    r.flags.carry           = d[8];
    r.flags.half_carry_flag = h[4];
    r.flags.zero            = (d[7:0] == 8'h00);
    r.flags_we              = (q.op != sia_pkg::SIA_OP_CLEAR_M);
    r.to_work = (q.op == sia_pkg::SIA_OP_SUBC_AM) ||
                (q.op == sia_pkg::SIA_OP_SUBC_A);
    r.to_mem  = ~r.to_work;
    if (!r.flags_we)
      r.data = 8'h00;
    return r;
  endfunction : model

  function automatic logic [15:0] route_bits(input sia_pkg::sia_rsp_t r);
    return {13'h0000, r.to_mem, r.to_work, r.flags_we};
  endfunction : route_bits

  // nine-bit result: wrap of the byte together with its borrow, or its carry for SIA_OP_INC_M
  function automatic logic [15:0] carry_data(input sia_pkg::sia_rsp_t r);
    return {7'h00, r.flags.carry, r.data};
  endfunction : carry_data

  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_bits(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bits

  task automatic send(input logic [2:0] op, input logic [7:0] w,
                      input logic [7:0] m, input logic c, input logic v);
    sia_pkg::sia_req_t q;
    q = {v, sia_pkg::sia_op_t'(op), w, m, c};
    @(posedge core_clk);
    req <= q;
    if (v)
    begin
      exp_q.push_back(model(q));
      op_q.push_back(q.op);
    end
  endtask : send

  task automatic final_report;
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // results are checked mid-cycle, once the launching edge has settled
  always @(negedge core_clk)
  begin
    if (rstn && rsp.valid === 1'b1 && exp_q.size() > 0)
    begin
      e   = exp_q.pop_front();
      eop = op_q.pop_front();
      case (eop)
        sia_pkg::SIA_OP_SUB_MA:  chk_data(rsp.data, e.data);
        sia_pkg::SIA_OP_SUBC_AM: chk_data(rsp.data, e.data);
        sia_pkg::SIA_OP_SUBC_MA: chk_data(rsp.data, e.data);
        sia_pkg::SIA_OP_SUBC_A:  chk_data(rsp.data, e.data);
        sia_pkg::SIA_OP_SUBC_M:  chk_data(rsp.data, e.data);
        sia_pkg::SIA_OP_INC_M:   chk_data(rsp.data, e.data);
        sia_pkg::SIA_OP_DEC_M:   chk_data(rsp.data, e.data);
        sia_pkg::SIA_OP_CLEAR_M: chk_data(rsp.data, e.data);
      endcase
      chk_bits(route_bits(rsp), route_bits(e));
      if (e.flags_we)
      begin
        chk_bits({12'h000, rsp.flags}, {12'h000, e.flags});
        chk_bits(carry_data(rsp), carry_data(e));
      end
    end
    else if (rstn)
      chk_bits(rsp, sia_pkg::RSP_RESET);
  end

  initial
  begin
    error_cnt   = 0;
    comparisons = 0;
    rstn        = 1'b0;
    req         = '0;
    void'($urandom(32'h900C3E77));
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    for (int op = 0; op < 8; op++)
      for (int i = 0; i < 6; i++)
        for (int j = 0; j < 12; j++)
        begin
          send(op[2:0], vals[i], vals[j % 6], j[0] ^ (j > 5), 1'b1);
          if ($urandom % 4 == 0)
            send(3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
        end
    repeat (300)
    begin
      rv = 20'($urandom);
      send(rv[2:0], rv[10:3], rv[18:11], rv[19], rv[0] | rv[5]);
    end
    send(3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
    repeat (3) @(posedge core_clk);
    chk_bits(16'(exp_q.size()), 16'h0000);
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    final_report();
  end
endmodule : test_subtract_increment_alu
